// File: src/owdr_pkg.sv
// Constants and types shared by the one-wire dimming receiver.
package owdr_pkg;

   // ----------------------------------------------------------------
   // Clock and timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 40;
   localparam int DET_DELAY_NS = 100_000;
   localparam int DET_TIME_NS = 260_000;
   localparam int DET_WIN_NS = 1_000_000;
   localparam int SHUTDOWN_NS = 2_500_000;
   localparam int ACK_PULSE_NS = 512_000;
   localparam int ACK_VALID_NS = 2_000;

   // Least times round up, longest times round down.
   localparam int DET_DELAY_CYC = (DET_DELAY_NS * CLK_MHZ + 999) / 1000;
   localparam int DET_TIME_CYC = (DET_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam int DET_WIN_CYC = (DET_WIN_NS * CLK_MHZ) / 1000;
   localparam int SHUTDOWN_CYC = (SHUTDOWN_NS * CLK_MHZ + 999) / 1000;
   localparam int ACK_PULSE_CYC = (ACK_PULSE_NS * CLK_MHZ) / 1000;
   localparam int ACK_VALID_CYC = (ACK_VALID_NS * CLK_MHZ + 999) / 1000;

   // ----------------------------------------------------------------
   // Frame layout and reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] DEV_ADDR = 8'h72;
   localparam logic [4:0] LEVEL_RESET = 5'h1F;
   localparam logic [4:0] BYTE_BITS = 5'h08;
   localparam logic [4:0] FRAME_BITS = 5'h10;

   typedef struct packed {
      logic ack_request_flag;
      logic subaddr_bit_high;
      logic subaddr_bit_low;
      logic [4:0] level_code;
   } owdr_data_t;

endpackage

// File: src/owdr_dur_counter.sv
// Saturating duration counter with synchronous clear.
`timescale 1ns/1ps
module owdr_dur_counter #(
   parameter int W = 17
) (
   input wire logic clk, // System clock.
   input wire logic rst, // Asynchronous reset, active high.
   input wire logic clr, // Restart the count at zero.
   input wire logic en, // Count this cycle.
   output logic [W-1:0] count // Cycles counted, held at all ones.
);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         count <= '0;
      end else if (clr) begin
         count <= '0;
      end else if (en && (count != {W{1'b1}})) begin
         count <= count + W'(1);
      end
   end

endmodule // owdr_dur_counter

// File: src/owdr_receiver.sv
// One-wire dimming receiver: mode detection, bit decoding, acknowledge.
//
// Contract
// - Both bytes are shifted in most significant bit first.
// - Address byte is accepted without start if line already high.
// - A bit lasts from one falling edge to the next.
// - One: high at least twice low; zero: low at least twice high.
// - Only frames whose address byte equals 72 hex are acted on.
// - Data byte: ack request, two subaddress bits, 5-bit level code.
// - Acknowledge only on request, matching address, 16 clean bits.
// - Acknowledge pulls line low for no more than 512 us.
// - Acknowledge starts after validation delay from final falling edge.
// - Level code selects one of 32 steps; full scale after enable.
// - Receiver works only after one-wire mode detection after enable.
// - Rates from 1.7 to 160 kbit/s decode with no configuration.
`timescale 1ns/1ps
module owdr_receiver #(
   parameter int CNT_W = 17,
   parameter int DET_TIME_CYC = owdr_pkg::DET_TIME_CYC,
   parameter int DET_WIN_CYC = owdr_pkg::DET_WIN_CYC,
   parameter int SHUTDOWN_CYC = owdr_pkg::SHUTDOWN_CYC,
   parameter int ACK_PULSE_CYC = owdr_pkg::ACK_PULSE_CYC
) (
   input wire logic CLK, // System clock, 40 MHz.
   input wire logic RST, // Asynchronous reset, active high.
   input wire logic CTRL_IN, // Dimming line level from the pin.
   output logic CTRL_OUT, // Dimming line drive value, always low.
   output logic CTRL_OE, // Pull-down enable, high while acknowledging.
   output logic [4:0] LEVEL, // Stored level code, feedback step index.
   output logic ONE_WIRE_MODE, // High once one-wire mode is detected.
   output logic FRAME_DONE, // One-cycle pulse: frame accepted.
   output logic FRAME_ERR // One-cycle pulse: frame discarded for a bad bit.
);

   // ----------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------
   if (CNT_W < 13 || CNT_W > 30) begin : g_bad_width
      $error("CNT_W out of range");
   end
   if (SHUTDOWN_CYC >= (1 << CNT_W) || DET_WIN_CYC >= (1 << CNT_W) ||
       ACK_PULSE_CYC >= (1 << CNT_W)) begin : g_bad_count
      $error("Counts do not fit CNT_W");
   end
   if (ACK_PULSE_CYC < 2 || DET_TIME_CYC < 1 ||
       DET_WIN_CYC <= owdr_pkg::DET_DELAY_CYC) begin : g_bad_time
      $error("Timing parameters inconsistent");
   end

   typedef enum logic [1:0] {M_OFF, M_WIN, M_PWM, M_ONE} owdr_mode_t;
   typedef enum logic [2:0] {L_IDLE, L_BIT, L_GAP, L_VALID, L_ACK}
      owdr_link_t;

   // ----------------------------------------------------------------
   // Line synchroniser and edges
   // ----------------------------------------------------------------
   logic line_meta_r;
   logic line_r;
   logic line_d_r;
   logic fall;

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         line_meta_r <= 1'b0;
         line_r <= 1'b0;
         line_d_r <= 1'b0;
      end else begin
         line_meta_r <= CTRL_IN;
         line_r <= line_meta_r;
         line_d_r <= line_r;
      end
   end

   assign fall = line_d_r & ~line_r;

   // ----------------------------------------------------------------
   // Duration counters
   // ----------------------------------------------------------------
   owdr_mode_t mode_r;
   owdr_link_t link_r;
   logic [CNT_W-1:0] win_cnt;
   logic [CNT_W-1:0] low_run;
   logic [CNT_W-1:0] low_cnt;
   logic [CNT_W-1:0] high_cnt;
   logic [CNT_W-1:0] tmr_cnt;
   logic past_delay;
   logic tmr_clr;

   assign past_delay = win_cnt >= CNT_W'(owdr_pkg::DET_DELAY_CYC);

   owdr_dur_counter #(.W(CNT_W)) u_win (
      .clk(CLK),
      .rst(RST),
      .clr(mode_r != M_WIN),
      .en(1'b1),
      .count(win_cnt)
   );

   // In the detection window, low run only counts once the detection delay has passed.
   owdr_dur_counter #(.W(CNT_W)) u_low_run (
      .clk(CLK),
      .rst(RST),
      .clr(line_r),
      .en(mode_r != M_WIN || past_delay),
      .count(low_run)
   );

   // Bit phases are measured in clocks and saturate, so slow rates
   // down to 1.7 kbit/s still fit without any setting.
   owdr_dur_counter #(.W(CNT_W)) u_low (
      .clk(CLK),
      .rst(RST),
      .clr(fall),
      .en(~line_r),
      .count(low_cnt)
   );

   owdr_dur_counter #(.W(CNT_W)) u_high (
      .clk(CLK),
      .rst(RST),
      .clr(fall),
      .en(line_r),
      .count(high_cnt)
   );

   owdr_dur_counter #(.W(CNT_W)) u_tmr (
      .clk(CLK),
      .rst(RST),
      .clr(tmr_clr),
      .en(1'b1),
      .count(tmr_cnt)
   );

   // ----------------------------------------------------------------
   // Dimming mode detection
   // ----------------------------------------------------------------
   logic enable_evt;

   assign enable_evt = (mode_r == M_OFF) && line_r;

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         mode_r <= M_OFF;
      end else begin
         unique case (mode_r)
            M_OFF: begin
               if (line_r) begin
                  mode_r <= M_WIN;
               end
            end
            M_WIN: begin
               if (low_run >= CNT_W'(DET_TIME_CYC)) begin
                  mode_r <= M_ONE;
               end else if (win_cnt >= CNT_W'(DET_WIN_CYC)) begin
                  mode_r <= M_PWM;
               end
            end
            M_PWM, M_ONE: begin
               // Long low shuts down; the mode is chosen again on enable.
               if (low_run >= CNT_W'(SHUTDOWN_CYC)) begin
                  mode_r <= M_OFF;
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Bit decoding and frame assembly
   // ----------------------------------------------------------------
   logic [CNT_W:0] low_x2;
   logic [CNT_W:0] high_x2;
   logic is_one;
   logic is_zero;
   logic [15:0] shift_r;
   logic [15:0] shift_nxt;
   logic [4:0] bit_cnt_r;
   logic err_r;
   logic err_nxt;
   logic last_bit;
   logic frame_good;
   owdr_pkg::owdr_data_t data_byte;

   assign low_x2 = {low_cnt, 1'b0};
   assign high_x2 = {high_cnt, 1'b0};
   assign is_one = {1'b0, high_cnt} >= low_x2;
   assign is_zero = {1'b0, low_cnt} >= high_x2;
   assign shift_nxt = {shift_r[14:0], is_one};
   assign err_nxt = err_r | ~(is_one ^ is_zero);
   assign last_bit = bit_cnt_r == (owdr_pkg::FRAME_BITS - 5'h01);
   assign data_byte = shift_nxt[7:0];
   assign frame_good = ~err_nxt &&
      (shift_nxt[15:8] == owdr_pkg::DEV_ADDR);

   // A bit is closed by the falling edge that opens the next one.
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         shift_r <= '0;
         bit_cnt_r <= '0;
         err_r <= 1'b0;
      end else if (link_r == L_IDLE) begin
         bit_cnt_r <= '0;
         err_r <= 1'b0;
      end else if (link_r == L_BIT && fall) begin
         shift_r <= shift_nxt;
         bit_cnt_r <= bit_cnt_r + 5'h01;
         err_r <= err_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Link sequencing and acknowledge
   // ----------------------------------------------------------------
   logic oe_nxt;

   assign tmr_clr = (link_r == L_BIT) ||
      (link_r == L_VALID && tmr_cnt ==
       CNT_W'(owdr_pkg::ACK_VALID_CYC - 1));
   assign oe_nxt = (link_r == L_VALID && tmr_clr) ||
      (link_r == L_ACK && tmr_cnt != CNT_W'(ACK_PULSE_CYC - 1));

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         link_r <= L_IDLE;
      end else if (mode_r != M_ONE) begin
         link_r <= L_IDLE;
      end else begin
         unique case (link_r)
            L_IDLE: begin
               // Line already high serves as the start condition.
               if (fall) begin
                  link_r <= L_BIT;
               end
            end
            L_BIT: begin
               if (fall && last_bit) begin
                  if (frame_good && data_byte.ack_request_flag) begin
                     link_r <= L_VALID;
                  end else begin
                     link_r <= L_IDLE;
                  end
               end else if (fall &&
                            bit_cnt_r == owdr_pkg::BYTE_BITS - 5'h01) begin
                  link_r <= L_GAP;
               end
            end
            L_GAP: begin
               // Close condition low, then the start condition's high
               // time; the fall after it opens the data byte. Going
               // through idle here would lose the bit count.
               if (fall) begin
                  link_r <= L_BIT;
               end
            end
            L_VALID: begin
               if (tmr_clr) begin
                  link_r <= L_ACK;
               end
            end
            L_ACK: begin
               if (!oe_nxt) begin
                  link_r <= L_IDLE;
               end
            end
            default: begin
               link_r <= L_IDLE;
            end
         endcase
      end
   end

   // The acknowledge ignores the line: our own pull-down owns it.
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         CTRL_OE <= 1'b0;
         CTRL_OUT <= 1'b0;
      end else begin
         CTRL_OE <= oe_nxt && mode_r == M_ONE;
         CTRL_OUT <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Level register and status
   // ----------------------------------------------------------------
   logic frame_end;

   assign frame_end = mode_r == M_ONE && link_r == L_BIT && fall &&
      last_bit;

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         LEVEL <= owdr_pkg::LEVEL_RESET;
      end else if (enable_evt) begin
         LEVEL <= owdr_pkg::LEVEL_RESET;
      end else if (frame_end && frame_good &&
                   !data_byte.subaddr_bit_high &&
                   !data_byte.subaddr_bit_low) begin
         LEVEL <= data_byte.level_code;
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         ONE_WIRE_MODE <= 1'b0;
         FRAME_DONE <= 1'b0;
         FRAME_ERR <= 1'b0;
      end else begin
         ONE_WIRE_MODE <= mode_r == M_ONE;
         FRAME_DONE <= frame_end && frame_good;
         FRAME_ERR <= frame_end && err_nxt;
      end
   end

endmodule // owdr_receiver

// File: test/owdr_receiver_monitor.sv
// Port assertions for the one-wire dimming receiver.
`timescale 1ns/1ps
module owdr_receiver_monitor #(
   parameter int ACK_PULSE_CYC = 16
) (
   input wire logic CLK, // Clock.
   input wire logic RST, // Reset.
   input wire logic CTRL_IN, // Line level.
   input wire logic CTRL_OUT, // Drive value.
   input wire logic CTRL_OE, // Pull-down enable.
   input wire logic [4:0] LEVEL, // Level code.
   input wire logic ONE_WIRE_MODE, // Mode flag.
   input wire logic FRAME_DONE, // Accept pulse.
   input wire logic FRAME_ERR // Discard pulse.
);
   localparam int VAL = owdr_pkg::ACK_VALID_CYC;
   int oe_cnt_r;
   int low_cnt_r;
   int since_done_r;
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         oe_cnt_r <= 0;
         low_cnt_r <= 0;
         since_done_r <= 1000;
      end else begin
         oe_cnt_r <= CTRL_OE ? oe_cnt_r + 1 : 0;
         low_cnt_r <= CTRL_IN ? 0 : low_cnt_r + 1;
         since_done_r <= FRAME_DONE ? 0 : since_done_r + 1;
      end
   end
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   property p_oe_len;
      $fell(CTRL_OE) |-> oe_cnt_r == ACK_PULSE_CYC;
   endproperty
   a_oe_len: assert property (p_oe_len)
      else $error("ack pulse length wrong");
   property p_oe_max;
      CTRL_OE |-> oe_cnt_r < ACK_PULSE_CYC;
   endproperty
   a_oe_max: assert property (p_oe_max)
      else $error("ack pulse too long");
   property p_ack_wait;
      $rose(CTRL_OE) |-> low_cnt_r >= VAL;
   endproperty
   a_ack_wait: assert property (p_ack_wait)
      else $error("ack before validation delay");
   property p_ack_cause;
      $rose(CTRL_OE) |-> since_done_r inside {[VAL - 4:VAL + 6]};
   endproperty
   a_ack_cause: assert property (p_ack_cause)
      else $error("ack without accepted frame");
   property p_out_low;
      CTRL_OE |-> CTRL_OUT == 1'b0 && ONE_WIRE_MODE;
   endproperty
   a_out_low: assert property (p_out_low)
      else $error("ack drive value wrong");
   property p_done_pulse;
      FRAME_DONE |=> !FRAME_DONE && !FRAME_ERR;
   endproperty
   a_done_pulse: assert property (p_done_pulse)
      else $error("done pulse too long");
   property p_excl;
      FRAME_ERR |-> !FRAME_DONE ##1 !FRAME_ERR;
   endproperty
   a_excl: assert property (p_excl)
      else $error("error pulse wrong");
   property p_level_chg;
      $changed(LEVEL) |-> FRAME_DONE || $past(FRAME_DONE) ||
         LEVEL == owdr_pkg::LEVEL_RESET;
   endproperty
   a_level_chg: assert property (p_level_chg)
      else $error("level changed without frame");
endmodule // owdr_receiver_monitor
bind owdr_receiver owdr_receiver_monitor #(.ACK_PULSE_CYC(ACK_PULSE_CYC))
   u_mon (.CLK(CLK), .RST(RST), .CTRL_IN(CTRL_IN), .CTRL_OUT(CTRL_OUT),
   .CTRL_OE(CTRL_OE), .LEVEL(LEVEL), .ONE_WIRE_MODE(ONE_WIRE_MODE),
   .FRAME_DONE(FRAME_DONE), .FRAME_ERR(FRAME_ERR));

// File: test/owdr_host_model.sv
// Open-drain host that drives the dimming line.
`timescale 1ns/1ps
module owdr_host_model (
   input wire logic clk, // Bench clock.
   input wire logic line, // Resolved line level.
   output logic pull_low // High while the host pulls the line low.
);
   logic ack_seen;
   initial pull_low = 1'b0;
   task automatic hold(input logic lo, input int n);
      pull_low = lo;
      repeat (n) @(negedge clk);
   endtask
   task automatic detect();
      hold(1'b0, 4010);
      hold(1'b1, 40);
      hold(1'b0, 100);
   endtask
   task automatic send_byte(input logic [7:0] b, input int u,
      input logic amb);
      hold(1'b0, 80);
      for (int i = 7; i >= 0; i--) begin
         if (amb && i == 0) begin
            hold(1'b1, 2 * u);
            hold(1'b0, 2 * u);
         end else begin
            hold(1'b1, b[i] ? u : 3 * u);
            hold(1'b0, b[i] ? 3 * u : u);
         end
      end
   endtask
   task automatic send_frame(input logic [7:0] a, input logic [7:0] d,
      input int u, input logic amb);
      send_byte(a, u, 1'b0);
      hold(1'b1, 100);
      send_byte(d, u, amb);
      hold(1'b1, owdr_pkg::ACK_VALID_CYC + 20);
      hold(1'b0, 2);
      ack_seen = d[7] && !line;
      hold(1'b0, 120);
   endtask
endmodule // owdr_host_model

// File: test/tb_one_wire_dimming_receiver.sv
// Self-checking bench for the one-wire dimming receiver.
`timescale 1ns/1ps
module tb_one_wire_dimming_receiver;
   logic clk;
   logic rst;
   logic oe;
   logic out;
   logic mode;
   logic done;
   logic err;
   logic [4:0] level;
   wire logic pull_low;
   wire logic line;
   int fails = 0;
   int cmp_count = 0;
   int cyc = 0;
   int done_n = 0;
   int err_n = 0;
   int oe_cyc = 0;
   int exp_level = 31;
   int exp_done = 0;
   int exp_err = 0;
   int exp_ack = 0;
   logic [7:0] data_q[$];
   // The line is pulled up; either party may pull it low.
   assign line = !(pull_low || (oe && !out));
   owdr_receiver #(.DET_TIME_CYC(20), .DET_WIN_CYC(4200),
      .SHUTDOWN_CYC(300), .ACK_PULSE_CYC(64)) DUT (
      .CLK(clk), .RST(rst), .CTRL_IN(line), .CTRL_OUT(out), .CTRL_OE(oe),
      .LEVEL(level), .ONE_WIRE_MODE(mode), .FRAME_DONE(done),
      .FRAME_ERR(err));
   owdr_host_model host (.clk(clk), .line(line), .pull_low(pull_low));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // ----------------------------------------------------------------
   // Checking and closing
   // ----------------------------------------------------------------
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   always @(posedge clk) begin
      cyc++;
      if (done) done_n++;
      if (err) err_n++;
      if (oe) oe_cyc++;
      if (cyc == 50000) begin
         fails++;
         close_out();
      end
   end
   task automatic run(input logic [7:0] a, input logic [7:0] d,
      input int u, input logic amb);
      logic good;
      good = (a == owdr_pkg::DEV_ADDR) && !amb;
      host.send_frame(a, d, u, amb);
      if (good) exp_done++;
      if (amb) exp_err++;
      if (good && d[6:5] == 2'b00) exp_level = d[4:0];
      if (good && d[7]) exp_ack++;
      check(level, exp_level);
      check(done_n, exp_done);
      check(err_n, exp_err);
      check(oe_cyc, exp_ack * 64);
      check(host.ack_seen, good && d[7]);
      $display("test frame %0h %0h finished", a, d);
   endtask
   initial begin
      rst = 1'b1;
      void'($urandom(51));
      repeat (16) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      check(level, 31);
      check(mode, 1'b0);
      host.detect();
      check(mode, 1'b1);
      $display("test mode detection finished");
      data_q = '{8'h00, 8'h1F};
      repeat (6) data_q.push_back(8'($urandom) & 8'h9F);
      foreach (data_q[i]) begin
         run(owdr_pkg::DEV_ADDR, data_q[i], i % 2 ? 3 : 16, 1'b0);
      end
      run(8'h4E, 8'h85, 16, 1'b0);
      run(8'h73, 8'h8A, 3, 1'b0);
      run(owdr_pkg::DEV_ADDR, 8'hC3, 16, 1'b0);
      run(owdr_pkg::DEV_ADDR, 8'hA3, 3, 1'b0);
      run(owdr_pkg::DEV_ADDR, 8'h89, 16, 1'b1);
      run(owdr_pkg::DEV_ADDR, 8'h96, 5, 1'b0);
      // A reset in mid-run brings back full scale and the one-wire
      // mode has to be detected again.
      rst = 1'b1;
      repeat (4) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      exp_level = 31;
      check(level, exp_level);
      check(mode, 1'b0);
      host.detect();
      check(mode, 1'b1);
      $display("test reset in mid-run finished");
      run(owdr_pkg::DEV_ADDR, 8'h8C, 3, 1'b0);
      // A long low shuts down; the level holds until the next enable.
      host.hold(1'b1, 320);
      check(mode, 1'b0);
      check(level, exp_level);
      // Enable without the detection low ends in the other mode.
      exp_level = 31;
      host.hold(1'b0, 4400);
      check(level, exp_level);
      check(mode, 1'b0);
      host.send_frame(owdr_pkg::DEV_ADDR, 8'h85, 16, 1'b0);
      check(done_n, exp_done);
      check(level, exp_level);
      check(oe_cyc, exp_ack * 64);
      check(host.ack_seen, 1'b0);
      $display("test shutdown and other mode finished");
      close_out();
   end
endmodule // tb_one_wire_dimming_receiver
